// [include/iet_pkg.sv]
// Purpose: shared constants and types of the two-wire memory target
// Assumes: system clock of 200 MHz
// Notes: memory size and page size are module parameters of the target
package iet_pkg;

    // =========================================================
    // device address word layout
    localparam logic [3:0] IET_TYPE_CODE = 4'ha;
    localparam int IET_TYPE_LSB = 4;
    localparam int IET_PAGE_MSB = 3;
    localparam int IET_PAGE_LSB = 1;
    localparam int IET_RW_BIT = 0;

    // =========================================================
    // array geometry and reset values
    localparam int IET_ADDR_W = 11;
    localparam int IET_PAGE_W = 4;
    localparam int IET_BITS_PER_WORD = 8;
    localparam logic [7:0] IET_ERASED = 8'hff;

    // =========================================================
    // timing
    localparam int IET_WRITE_TIME_MS = 5;
    localparam int IET_CLK_PERIOD_PS = 5000;
    localparam longint IET_PS_PER_MS = 64'h0000_0000_3b9a_ca00;
    localparam int IET_WRITE_CYCLES = int'(longint'(IET_WRITE_TIME_MS) * IET_PS_PER_MS
        / longint'(IET_CLK_PERIOD_PS));

    // =========================================================
    // protocol engine states
    typedef enum logic [2:0]
    {
        IET_ST_IDLE,
        IET_ST_DEV,
        IET_ST_WADDR,
        IET_ST_WDATA,
        IET_ST_ACK,
        IET_ST_READ,
        IET_ST_MACK,
        IET_ST_IGNORE
    } iet_state_type;

endpackage

// [rtl/iet_target.sv]
// Purpose: two-wire serial target for a byte-wide nonvolatile array
// Assumes: link_clk oversamples scl and sda; clk times the write cycle
// Notes: array is flip-flops; write data is held in a page buffer until stop
//
// Overview of operation
// RQ1: sda changes only while scl low; sda change with scl high is start/stop.
// RQ2: falling sda with scl high is a start; every command begins with one.
// RQ3: rising sda with scl high is a stop; after a read it means standby.
// RQ4: words are eight bits; device pulls sda low on ninth clock to acknowledge.
// RQ5: standby at power-up and after stop once internal work has finished.
// RQ6: controller recovers bus with start, nine clocks, start, then stop.
// RQ7: self-timed write begins at stop ending a write and runs until programmed.
// RQ8: device address word starts with type code 1010; respond only on match.
// RQ9: address bits 3..1 are the top three bits of the eleven-bit word address.
// RQ10: address bit 0 high means read, low means write.
// RQ11: acknowledge a matching address; on mismatch stay silent and go to standby.
// RQ12: byte write acknowledges address, word address, one data byte, then stop.
// RQ13: during the write cycle ignore the bus and acknowledge nothing.
// RQ14: page write takes up to sixteen data bytes, each acknowledged.
// RQ15: writes advance only the low four address bits, wrapping within the page.
// RQ16: polling address is acknowledged only after the write cycle completes.
// RQ17: address counter holds last accessed address plus one across operations.
// RQ18: reads wrap from the last byte of the array to the first.
// RQ19: current read shifts out byte at the counter; controller then no-acks, stops.
// RQ20: random read loads word address by dummy write, then repeated start and read.
// RQ21: each controller acknowledge advances the address and sends the next byte.
// RQ22: sample incoming bits on scl rise, change outgoing bits after scl fall.
// RQ23: array is 128 pages of 16 bytes under an eleven-bit word address.
// RQ24: write protect high blocks all writes; low allows normal writes.
// RQ25: write cycle length is a parameter in clock cycles, default the maximum.
// RQ26: when protected, bytes are still acknowledged but nothing is programmed.
`timescale 1ns/1ps

module iet_target
#(
    parameter int ADDR_W = iet_pkg::IET_ADDR_W,
    parameter int PAGE_W = iet_pkg::IET_PAGE_W,
    parameter int WRITE_CYCLES = iet_pkg::IET_WRITE_CYCLES
)
(
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link side
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic wp_i,
    // status
    output logic standby_o,
    output logic write_busy_o
);

    localparam int DEPTH = 1 << ADDR_W;
    localparam int PAGE = 1 << PAGE_W;
    localparam int BW = iet_pkg::IET_BITS_PER_WORD;
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    // =========================================================
    // state records
    typedef struct packed
    {
        logic rst_s1;
        logic rst_s2;
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic wp_s1;
        logic wp_s2;
        logic ack_s1;
        logic ack_s2;
        logic req_t;
        iet_pkg::iet_state_type state;
        iet_pkg::iet_state_type after;
        logic [3:0] cnt;
        logic [BW-1:0] shreg;
        logic [BW-1:0] data;
        logic [2:0] page;
        logic [ADDR_W-1:0] addr;
        logic [PAGE-1:0][BW-1:0] pbuf;
        logic [PAGE-1:0] valid;
        logic pend;
        logic oe;
        logic lo;
        logic standby;
        logic [DEPTH-1:0][BW-1:0] mem;
    } iet_link_type;

    typedef struct packed
    {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_t;
        logic busy;
        logic [CNT_W-1:0] count;
    } iet_core_type;

    iet_link_type l_q;
    iet_link_type l_d;
    iet_core_type c_q;
    iet_core_type c_d;

    // =========================================================
    // address arithmetic
    function automatic logic [ADDR_W-1:0] next_in_page(input logic [ADDR_W-1:0] a);
        logic [PAGE_W-1:0] low;
        low = a[PAGE_W-1:0] + PAGE_W'(1);
        return {a[ADDR_W-1:PAGE_W], low};
    endfunction

    function automatic logic [ADDR_W-1:0] next_linear(input logic [ADDR_W-1:0] a);
        return a + ADDR_W'(1);
    endfunction

    // =========================================================
    // link events, all taken from the second or later sync stage
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic busy;
    logic addr_match;

    assign scl_rise = l_q.scl_s2 && !l_q.scl_p; // RQ22
    assign scl_fall = !l_q.scl_s2 && l_q.scl_p; // RQ22
    assign start_seen = l_q.scl_s2 && l_q.scl_p && l_q.sda_p && !l_q.sda_s2; // RQ1 RQ2
    assign stop_seen = l_q.scl_s2 && l_q.scl_p && !l_q.sda_p && l_q.sda_s2; // RQ1 RQ3
    assign busy = l_q.req_t != l_q.ack_s2;
    assign addr_match = l_q.shreg[BW-1:iet_pkg::IET_TYPE_LSB] == iet_pkg::IET_TYPE_CODE; // RQ8

    // =========================================================
    // link domain: protocol engine and array
    always_comb
    begin
        l_d = l_q;
        l_d.rst_s1 = rst_n;
        l_d.rst_s2 = l_q.rst_s1;
        l_d.scl_s1 = scl_i;
        l_d.scl_s2 = l_q.scl_s1;
        l_d.scl_p = l_q.scl_s2;
        l_d.sda_s1 = sda_i;
        l_d.sda_s2 = l_q.sda_s1;
        l_d.sda_p = l_q.sda_s2;
        l_d.wp_s1 = wp_i;
        l_d.wp_s2 = l_q.wp_s1;
        l_d.ack_s1 = c_q.ack_t;
        l_d.ack_s2 = l_q.ack_s1;
        l_d.lo = 1'h0;
        l_d.standby = (l_q.state == iet_pkg::IET_ST_IDLE) && !busy; // RQ5
        if (!l_q.rst_s2)
        begin
            l_d.req_t = 1'h0;
            l_d.state = iet_pkg::IET_ST_IDLE; // RQ5
            l_d.after = iet_pkg::IET_ST_IDLE;
            l_d.cnt = 4'h0;
            l_d.shreg = 8'h00;
            l_d.data = 8'h00;
            l_d.page = 3'h0;
            l_d.addr = '0;
            l_d.pbuf = '0;
            l_d.valid = '0;
            l_d.pend = 1'h0;
            l_d.oe = 1'h0;
            l_d.standby = 1'h0;
            l_d.mem = {DEPTH{iet_pkg::IET_ERASED}};
        end
        else if (start_seen)
        begin
            // a repeated start abandons any unfinished page load
            l_d.state = iet_pkg::IET_ST_DEV; // RQ2
            l_d.cnt = 4'h0;
            l_d.oe = 1'h0;
            l_d.pend = 1'h0;
            l_d.valid = '0;
        end
        else if (stop_seen)
        begin
            l_d.state = iet_pkg::IET_ST_IDLE; // RQ3
            l_d.oe = 1'h0;
            l_d.pend = 1'h0;
            l_d.valid = '0;
            if (l_q.pend && !l_q.wp_s2) // RQ24 RQ26
            begin
                for (int i = 0; i < PAGE; i++)
                begin
                    if (l_q.valid[i])
                    begin
                        l_d.mem[{l_q.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] = l_q.pbuf[i]; // RQ7
                    end
                end
                l_d.req_t = !l_q.req_t; // RQ7
            end
        end
        else if (scl_rise)
        begin
            unique case (l_q.state)
                iet_pkg::IET_ST_DEV, iet_pkg::IET_ST_WADDR, iet_pkg::IET_ST_WDATA:
                begin
                    l_d.shreg = {l_q.shreg[BW-2:0], l_q.sda_s2}; // RQ4
                    l_d.cnt = l_q.cnt + 4'h1;
                end
                iet_pkg::IET_ST_READ:
                begin
                    l_d.cnt = l_q.cnt + 4'h1;
                end
                iet_pkg::IET_ST_MACK:
                begin
                    if (!l_q.sda_s2)
                    begin
                        l_d.data = l_q.mem[l_q.addr]; // RQ21
                        l_d.addr = next_linear(l_q.addr); // RQ18 RQ21
                        l_d.after = iet_pkg::IET_ST_READ;
                        l_d.state = iet_pkg::IET_ST_ACK;
                    end
                    else
                    begin
                        l_d.state = iet_pkg::IET_ST_IGNORE; // RQ19
                    end
                end
                iet_pkg::IET_ST_IDLE, iet_pkg::IET_ST_ACK, iet_pkg::IET_ST_IGNORE:
                begin
                    l_d.cnt = l_q.cnt;
                end
            endcase
        end
        else if (scl_fall)
        begin
            unique case (l_q.state)
                iet_pkg::IET_ST_DEV:
                begin
                    if (l_q.cnt == 4'h8)
                    begin
                        l_d.cnt = 4'h0;
                        if (addr_match && !busy) // RQ11 RQ13 RQ16
                        begin
                            l_d.oe = 1'h1; // RQ4 RQ11
                            l_d.state = iet_pkg::IET_ST_ACK;
                            l_d.page = l_q.shreg[iet_pkg::IET_PAGE_MSB:iet_pkg::IET_PAGE_LSB]; // RQ9
                            if (l_q.shreg[iet_pkg::IET_RW_BIT]) // RQ10
                            begin
                                l_d.data = l_q.mem[l_q.addr]; // RQ19 RQ17
                                l_d.addr = next_linear(l_q.addr); // RQ17 RQ18
                                l_d.after = iet_pkg::IET_ST_READ;
                            end
                            else
                            begin
                                l_d.after = iet_pkg::IET_ST_WADDR;
                            end
                        end
                        else
                        begin
                            l_d.state = iet_pkg::IET_ST_IDLE; // RQ11
                        end
                    end
                end
                iet_pkg::IET_ST_WADDR:
                begin
                    if (l_q.cnt == 4'h8)
                    begin
                        l_d.cnt = 4'h0;
                        l_d.addr = ADDR_W'({l_q.page, l_q.shreg}); // RQ9 RQ20 RQ23
                        l_d.oe = 1'h1; // RQ12
                        l_d.after = iet_pkg::IET_ST_WDATA;
                        l_d.state = iet_pkg::IET_ST_ACK;
                    end
                end
                iet_pkg::IET_ST_WDATA:
                begin
                    if (l_q.cnt == 4'h8)
                    begin
                        l_d.cnt = 4'h0;
                        l_d.pbuf[l_q.addr[PAGE_W-1:0]] = l_q.shreg; // RQ14 RQ15
                        l_d.valid[l_q.addr[PAGE_W-1:0]] = 1'h1;
                        l_d.addr = next_in_page(l_q.addr); // RQ15
                        l_d.pend = 1'h1; // RQ12
                        l_d.oe = 1'h1; // RQ14 RQ26
                        l_d.after = iet_pkg::IET_ST_WDATA;
                        l_d.state = iet_pkg::IET_ST_ACK;
                    end
                end
                iet_pkg::IET_ST_ACK:
                begin
                    // ninth clock over: release, or present first read bit
                    l_d.cnt = 4'h0;
                    l_d.state = l_q.after;
                    l_d.oe = (l_q.after == iet_pkg::IET_ST_READ) ? !l_q.data[BW-1] : 1'h0; // RQ22
                end
                iet_pkg::IET_ST_READ:
                begin
                    if (l_q.cnt == 4'h8)
                    begin
                        l_d.cnt = 4'h0;
                        l_d.oe = 1'h0;
                        l_d.state = iet_pkg::IET_ST_MACK;
                    end
                    else
                    begin
                        l_d.data = {l_q.data[BW-2:0], 1'h0};
                        l_d.oe = !l_q.data[BW-2]; // RQ22
                    end
                end
                iet_pkg::IET_ST_IDLE, iet_pkg::IET_ST_MACK, iet_pkg::IET_ST_IGNORE:
                begin
                    l_d.cnt = l_q.cnt;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk)
    begin
        l_q <= l_d;
    end

    // =========================================================
    // system domain: self-timed write cycle
    always_comb
    begin
        c_d = c_q;
        c_d.req_s1 = l_q.req_t;
        c_d.req_s2 = c_q.req_s1;
        if (!rst_n)
        begin
            c_d.req_seen = 1'h0;
            c_d.ack_t = 1'h0;
            c_d.busy = 1'h0;
            c_d.count = '0;
        end
        else if (c_q.busy)
        begin
            if (c_q.count == '0)
            begin
                c_d.busy = 1'h0;
                c_d.ack_t = c_q.req_seen; // RQ7 RQ16
            end
            else
            begin
                c_d.count = c_q.count - CNT_W'(1); // RQ25
            end
        end
        else if (c_q.req_s2 != c_q.req_seen)
        begin
            c_d.req_seen = c_q.req_s2;
            c_d.busy = 1'h1; // RQ7
            c_d.count = CNT_W'(WRITE_CYCLES - 1); // RQ25
        end
    end

    always_ff @(posedge clk)
    begin
        c_q <= c_d;
    end

    // =========================================================
    // outputs
    assign sda_o = l_q.lo;
    assign sda_oe = l_q.oe;
    assign standby_o = l_q.standby;
    assign write_busy_o = c_q.busy;

endmodule

// [tb/iet_chk.sv]
// Purpose: port checks for the two-wire memory target
// Assumes: bound to iet_target
// Notes: busy length counted in clk cycles
`timescale 1ns/1ps

module iet_chk
#(
    parameter int WRITE_CYCLES = iet_pkg::IET_WRITE_CYCLES
)
(
    // clocks and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    // link
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic wp_i,
    // status
    input wire logic standby_o,
    input wire logic write_busy_o
);
    // ========
    // run counters
    int bcnt_q;
    int ocnt_q;
    always_ff @(posedge clk)
        bcnt_q <= (!rst_n || !write_busy_o) ? 0 : bcnt_q + 1;
    always_ff @(posedge link_clk)
        ocnt_q <= (!rst_n || !sda_oe) ? 0 : ocnt_q + 1;

    // ========
    // checks
    property p_od; @(posedge link_clk) disable iff (!rst_n) sda_oe |-> !sda_o; endproperty
    a_od: assert property (p_od) else $error("sda driven high");
    property p_chg; @(posedge link_clk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_i && !$past(scl_i, 3);
    endproperty
    a_chg: assert property (p_chg) else $error("sda moved outside scl low");
    property p_quiet; @(posedge clk) disable iff (!rst_n) write_busy_o |-> !sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("driven during write cycle");
    property p_bsb; @(posedge link_clk) disable iff (!rst_n) write_busy_o |=> !standby_o; endproperty
    a_bsb: assert property (p_bsb) else $error("standby during write cycle");
    property p_len; @(posedge clk) disable iff (!rst_n) $fell(write_busy_o) |-> bcnt_q == WRITE_CYCLES; endproperty
    a_len: assert property (p_len) else $error("write cycle length wrong");
    property p_sbq; @(posedge link_clk) disable iff (!rst_n) standby_o |-> !sda_oe; endproperty
    a_sbq: assert property (p_sbq) else $error("driven in standby");
    // longest drive: address ack plus an all-zero byte, nine bench scl periods
    property p_run; @(posedge link_clk) disable iff (!rst_n) ocnt_q <= 120; endproperty
    a_run: assert property (p_run) else $error("sda held too long");
    property p_beg; @(posedge clk) disable iff (!rst_n) $rose(write_busy_o) |-> scl_i && sda_i; endproperty
    a_beg: assert property (p_beg) else $error("write cycle without stop");
endmodule

// [tb/iet_ctrl.sv]
// Purpose: two-wire bus controller model
// Assumes: sda resolved outside with pull-up
// Notes: scl stands high between frames
`timescale 1ns/1ps

module iet_ctrl
(
    // clock and data line
    input wire logic clk,
    input wire logic sda,
    // bus drive
    output logic scl,
    output logic sda_low
);
    localparam int T = 32;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ========
    // bus tasks
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic clk_bit(input logic b, output logic r);
        sda_low <= !b;
        w(2 * T);
        scl <= 1'b1;
        w(T);
        r = sda;
        w(T);
        scl <= 1'b0;
        w(T);
    endtask
    task automatic start;
        sda_low <= 1'b0;
        w(2 * T);
        scl <= 1'b1;
        w(2 * T);
        sda_low <= 1'b1;
        w(2 * T);
        scl <= 1'b0;
        w(T);
    endtask
    task automatic stop;
        sda_low <= 1'b1;
        w(T);
        scl <= 1'b1;
        w(2 * T);
        sda_low <= 1'b0;
        w(3 * T);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(!more, r);
    endtask
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench of the two-wire memory target
// Assumes: controller model drives scl and sda
// Notes: short write cycle parameter
`timescale 1ns/1ps

module tb_top;
    localparam int WC = 2000;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_i = 1'b0;
    logic sda_o, sda_oe, standby_o, write_busy_o, scl, sda_low, ack;
    wire sda = !(sda_low || (sda_oe && !sda_o));
    logic [7:0] mem [2048];
    logic [7:0] d;
    logic [10:0] a;
    int num_errors = 0;
    int checks_done = 0;
    initial forever #2.5 clk = ~clk;
    initial
    begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    iet_target #(.WRITE_CYCLES(WC)) i_iet_target (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .standby_o(standby_o),
        .write_busy_o(write_busy_o));
    iet_ctrl i_iet_ctrl (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    // ========
    // helpers
    function automatic logic [7:0] dev(input logic [10:0] ad, input logic rw);
        return {iet_pkg::IET_TYPE_CODE, ad[10:8], rw};
    endfunction
    task automatic finish_test;
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic snd(input logic [7:0] b, input logic e);
        i_iet_ctrl.send(b, ack);
        chk({7'h00, ack}, {7'h00, e});
    endtask
    task automatic poll(input logic [10:0] ad, output logic k);
        i_iet_ctrl.start();
        i_iet_ctrl.send(dev(ad, 1'b0), k);
        i_iet_ctrl.stop();
    endtask
    task automatic wr(input logic [10:0] ad, input int n);
        i_iet_ctrl.start();
        snd(dev(ad, 1'b0), 1'b1);
        snd(ad[7:0], 1'b1);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            snd(d, 1'b1);
            if (!wp_i) mem[{ad[10:4], ad[3:0] + i[3:0]}] = d;
        end
        i_iet_ctrl.stop();
    endtask
    task automatic rd(input logic [10:0] ad, input int n);
        i_iet_ctrl.start();
        snd(dev(ad, 1'b0), 1'b1);
        snd(ad[7:0], 1'b1);
        i_iet_ctrl.start();
        snd(dev(ad, 1'b1), 1'b1);
        for (int i = 0; i < n; i++)
        begin
            i_iet_ctrl.recv(i < n - 1, d);
            chk(d, mem[ad + 11'(i)]);
        end
        i_iet_ctrl.stop();
    endtask

    // ========
    // sequence
    initial
    begin
        void'($urandom(75));
        for (int i = 0; i < 2048; i++) mem[i] = iet_pkg::IET_ERASED;
        repeat (140) @(posedge clk);
        rst_n <= 1'b1;
        repeat (60) @(posedge clk);
        chk({7'h00, standby_o}, 8'h01);
        a = 11'($urandom);
        wr(a, 17);
        poll(a, ack);
        chk({7'h00, ack}, 8'h00);
        for (int i = 0; i < 4 && !ack; i++) poll(a, ack);
        chk({7'h00, ack}, 8'h01);
        a = {a[10:4], 4'hd};
        rd(a, 4);
        a = a + 11'h004;
        i_iet_ctrl.start();
        snd(dev(a, 1'b1), 1'b1);
        i_iet_ctrl.recv(1'b0, d);
        chk(d, mem[a]);
        i_iet_ctrl.stop();
        rd(11'h7ff, 2);
        i_iet_ctrl.start();
        snd({4'hb, a[10:8], 1'b0}, 1'b0);
        i_iet_ctrl.stop();
        repeat (60) @(posedge clk);
        chk({7'h00, standby_o}, 8'h01);
        a = 11'($urandom);
        wp_i <= 1'b1;
        wr(a, 1);
        wp_i <= 1'b0;
        poll(a, ack);
        chk({7'h00, ack}, 8'h01);
        i_iet_ctrl.start();
        snd(dev(a, 1'b0), 1'b1);
        for (int i = 0; i < 3; i++) i_iet_ctrl.clk_bit(1'b0, ack);
        i_iet_ctrl.start();
        for (int i = 0; i < 9; i++) i_iet_ctrl.clk_bit(1'b1, ack);
        i_iet_ctrl.start();
        i_iet_ctrl.stop();
        rd(a, 1);
        finish_test();
    end
    initial
    begin
        // traffic above takes about 73k cycles
        repeat (95000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule

bind iet_target iet_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_iet_chk (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .standby_o(standby_o),
    .write_busy_o(write_busy_o));
